// >>> bcpm_defines.svh
// Constants for the bridge control and power management capability registers.
// Behaviour
// - Control bit 16 enables poisoned packet detection.
// - Control bit 17 gates secondary error message forwarding.
// - ISA bit limits I/O to top 768 bytes.
// - VGA bit forwards legacy video memory range.
// - VGA I/O ranges 3B0-3BBh and 3C0-3DFh forwarded.
// - Control bit 20 selects 10 or 16-bit decode.
// - Downstream bit 22 asserts own port reset.
// - Upstream bit 22 resets all downstream ports.
// - Bits 21 and 23-27 read zero always.
// - Capability ID low byte reads 01h.
// - Next pointer 5Ch upstream, 4Ch downstream.
// - Bits 18:16 read 011b for revision.
// - Bit 21 defaults zero, loadable.
// - Auxiliary current bits 24:22 default 111b, loadable.
// - D1 and D2 support bits default one.
// - Bits 31:27 default 11111b, loadable.
`ifndef BCPM_DEFINES_SVH
`define BCPM_DEFINES_SVH

`define BCPM_ADDR_W      8
`define BCPM_OFS_BRCTL   8'h3C
`define BCPM_OFS_PMCAP   8'h40

`define BCPM_BIT_PERR    16
`define BCPM_BIT_ERR_FWD 17
`define BCPM_BIT_ISA     18
`define BCPM_BIT_VGA     19
`define BCPM_BIT_VGA16   20
`define BCPM_BIT_SBR     22
`define BCPM_CTL_LANE    2

`define BCPM_CAP_ID      8'h01
`define BCPM_NXT_UP      8'h5C
`define BCPM_NXT_DN      8'h4C
`define BCPM_PM_REV      3'h3
`define BCPM_LD_W        11
`define BCPM_LD_RST      11'h7FE
`define BCPM_LD_LSB      21
`define BCPM_LD_MSB      31
`define BCPM_ID_MSB      7
`define BCPM_NXT_LSB     8
`define BCPM_NXT_MSB     15
`define BCPM_REV_LSB     16
`define BCPM_REV_MSB     18

`define BCPM_VGA_IO0_LO  10'h3B0
`define BCPM_VGA_IO0_HI  10'h3BB
`define BCPM_VGA_IO1_LO  10'h3C0
`define BCPM_VGA_IO1_HI  10'h3DF
`define BCPM_IO_LO_W     10
`define BCPM_IO_64K_LSB  16
`define BCPM_ISA_SEL_LSB 8
`define BCPM_VGA_MEM_LO  32'h000A_0000
`define BCPM_VGA_MEM_HI  32'h000B_FFFF

`endif

// >>> bcpm_pkg.sv
// Types shared by the bridge control and power management logic.
package bcpm_pkg;

  typedef enum logic [0:0] {
    BCPM_ROLE_DOWN = 1'b0,
    BCPM_ROLE_UP   = 1'b1
  } bcpm_role_e;

  typedef enum logic [1:0] {
    BCPM_ERR_COR      = 2'h0,
    BCPM_ERR_NONFATAL = 2'h1,
    BCPM_ERR_FATAL    = 2'h3
  } bcpm_err_e;

  typedef struct packed {
    logic vga16_en;
    logic vga_en;
    logic isa_en;
  } bcpm_dec_ctl_s;

endpackage

// >>> bcpm_dec_if.sv
// Carrier between the register bank and the address forwarding decoder.
`timescale 1ns/10ps
interface bcpm_dec_if;
  bcpm_pkg::bcpm_dec_ctl_s ctl;
  logic [31:0]             io_addr;
  logic                    io_in_win;
  logic [31:0]             mem_addr;
  logic                    io_fwd;
  logic                    vga_io_hit;
  logic                    vga_mem_hit;

  modport regs (
    output ctl,
    output io_addr,
    output io_in_win,
    output mem_addr,
    input  io_fwd,
    input  vga_io_hit,
    input  vga_mem_hit
  );

  modport dec (
    input  ctl,
    input  io_addr,
    input  io_in_win,
    input  mem_addr,
    output io_fwd,
    output vga_io_hit,
    output vga_mem_hit
  );
endinterface

// >>> bcpm_fwd_dec.sv
// Address decoder for ISA limited I/O and legacy video forwarding.
`timescale 1ns/10ps
`include "bcpm_defines.svh"
module bcpm_fwd_dec (
  // Decode carrier
  bcpm_dec_if.dec d
);

  logic                     first_64k;
  logic                     isa_ok;
  logic [`BCPM_IO_LO_W-1:0] lo10;
  logic                     vga_io_rng;
  logic                     upper_ok;

  always_comb begin
    first_64k  = (d.io_addr[31:`BCPM_IO_64K_LSB] == 16'h0000);
    lo10       = d.io_addr[`BCPM_IO_LO_W-1:0];
    // Top 768 bytes of each 1KB block have a nonzero bits 9:8.
    isa_ok     = !d.ctl.isa_en ||
                 (first_64k && (d.io_addr[`BCPM_IO_LO_W-1:`BCPM_ISA_SEL_LSB] != 2'h0));
    vga_io_rng = ((lo10 >= `BCPM_VGA_IO0_LO) && (lo10 <= `BCPM_VGA_IO0_HI)) ||
                 ((lo10 >= `BCPM_VGA_IO1_LO) && (lo10 <= `BCPM_VGA_IO1_HI));
    upper_ok   = !d.ctl.vga16_en ||
                 (d.io_addr[`BCPM_IO_64K_LSB-1:`BCPM_IO_LO_W] == 6'h00);
    d.vga_io_hit  = d.ctl.vga_en && first_64k && vga_io_rng && upper_ok;
    d.vga_mem_hit = d.ctl.vga_en && (d.mem_addr >= `BCPM_VGA_MEM_LO) &&
                    (d.mem_addr <= `BCPM_VGA_MEM_HI);
    d.io_fwd      = (d.io_in_win && isa_ok) || d.vga_io_hit;
  end

endmodule

// >>> bcpm_regs.sv
// Bridge control and power management capability registers of one switch port.
`timescale 1ns/10ps
`include "bcpm_defines.svh"
module bcpm_regs #(
  parameter int PORT_COUNT = 2,
  parameter int OWN_PORT   = 0
) (
  // Clock, reset and enable
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     ce_i,
  // Port role strap, one when this is the upstream port
  input  wire logic                     is_upstream_i,
  // Configuration requests from the upstream link
  input  wire logic                     cfg_req_i,
  input  wire logic                     cfg_we_i,
  input  wire logic [`BCPM_ADDR_W-1:0]  cfg_addr_i,
  input  wire logic [3:0]               cfg_be_i,
  input  wire logic [31:0]              cfg_wdata_i,
  output logic                          cfg_ack_o,
  output logic [31:0]                   cfg_rdata_o,
  // Management bus or EEPROM load of capability bits 31:21
  input  wire logic                     cap_ld_we_i,
  input  wire logic [`BCPM_LD_W-1:0]    cap_ld_data_i,
  // Secondary side poisoned packets and error messages
  input  wire logic                     poison_i,
  input  wire logic                     err_msg_valid_i,
  input  wire bcpm_pkg::bcpm_err_e      err_msg_type_i,
  output logic                          poison_det_o,
  output logic                          err_fwd_o,
  output bcpm_pkg::bcpm_err_e           err_fwd_type_o,
  // Address forwarding decode
  input  wire logic                     dec_req_i,
  input  wire logic [31:0]              io_addr_i,
  input  wire logic                     io_in_win_i,
  input  wire logic [31:0]              mem_addr_i,
  output logic                          dec_ack_o,
  output logic                          io_fwd_o,
  output logic                          vga_io_fwd_o,
  output logic                          vga_mem_fwd_o,
  // Hot reset
  output logic                          hot_reset_o,
  output logic [PORT_COUNT-1:0]         port_rst_n_o
);

  generate
    if (PORT_COUNT < 1 || OWN_PORT < 0 || OWN_PORT >= PORT_COUNT) begin : g_chk
      $error("bcpm_regs: OWN_PORT must index one of PORT_COUNT ports");
    end
  endgenerate

  // Control and state registers.
  logic                     strap_done_ff;
  bcpm_pkg::bcpm_role_e     role_ff;
  logic                     perr_en_ff;
  logic                     err_fwd_en_ff;
  logic                     isa_en_ff;
  logic                     vga_en_ff;
  logic                     vga16_ff;
  logic                     sbr_ff;
  logic [`BCPM_LD_W-1:0]    cap_ld_ff;

  // Read assembly.
  logic [31:0]              brctl_rd;
  logic [31:0]              pmcap_rd;
  logic [7:0]               nxt_ptr;
  logic [31:0]              nxt_rdata;
  logic                     ctl_wr;

  // Decoder carrier.
  bcpm_dec_if dec_bus ();

  bcpm_fwd_dec bcpm_fwd_dec_inst (
    .d (dec_bus)
  );

  assign dec_bus.ctl.isa_en   = isa_en_ff;
  assign dec_bus.ctl.vga_en   = vga_en_ff;
  assign dec_bus.ctl.vga16_en = vga16_ff;
  assign dec_bus.io_addr      = io_addr_i;
  assign dec_bus.io_in_win    = io_in_win_i;
  assign dec_bus.mem_addr     = mem_addr_i;

  // The role strap is caught on the first enabled edge after reset release.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      strap_done_ff <= 1'b0;
    end else if (ce_i) begin
      strap_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      role_ff <= bcpm_pkg::BCPM_ROLE_DOWN;
    end else if (ce_i && !strap_done_ff) begin
      role_ff <= is_upstream_i ? bcpm_pkg::BCPM_ROLE_UP : bcpm_pkg::BCPM_ROLE_DOWN;
    end
  end

  // Only lane 2 of the control word holds writable bits.
  assign ctl_wr = ce_i && cfg_req_i && cfg_we_i && (cfg_addr_i == `BCPM_OFS_BRCTL) &&
                  cfg_be_i[`BCPM_CTL_LANE];

  // Writable bridge control bits; all reset to zero.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      perr_en_ff <= 1'b0;
    end else if (ctl_wr) begin
      perr_en_ff <= cfg_wdata_i[`BCPM_BIT_PERR];
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      err_fwd_en_ff <= 1'b0;
    end else if (ctl_wr) begin
      err_fwd_en_ff <= cfg_wdata_i[`BCPM_BIT_ERR_FWD];
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      isa_en_ff <= 1'b0;
      vga_en_ff <= 1'b0;
      vga16_ff  <= 1'b0;
    end else if (ctl_wr) begin
      isa_en_ff <= cfg_wdata_i[`BCPM_BIT_ISA];
      vga_en_ff <= cfg_wdata_i[`BCPM_BIT_VGA];
      vga16_ff  <= cfg_wdata_i[`BCPM_BIT_VGA16];
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sbr_ff <= 1'b0;
    end else if (ctl_wr) begin
      sbr_ff <= cfg_wdata_i[`BCPM_BIT_SBR];
    end
  end

  // Loadable capability defaults, replaced by management bus or EEPROM.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cap_ld_ff <= `BCPM_LD_RST;
    end else if (ce_i && cap_ld_we_i) begin
      cap_ld_ff <= cap_ld_data_i;
    end
  end

  // Read values of both registers.
  always_comb begin
    brctl_rd = 32'h0000_0000;
    brctl_rd[`BCPM_BIT_PERR]  = perr_en_ff;
    brctl_rd[`BCPM_BIT_ERR_FWD] = err_fwd_en_ff;
    brctl_rd[`BCPM_BIT_ISA]   = isa_en_ff;
    brctl_rd[`BCPM_BIT_VGA]   = vga_en_ff;
    brctl_rd[`BCPM_BIT_VGA16] = vga16_ff;
    brctl_rd[`BCPM_BIT_SBR]   = sbr_ff;
  end

  always_comb begin
    nxt_ptr = (role_ff == bcpm_pkg::BCPM_ROLE_UP) ? `BCPM_NXT_UP : `BCPM_NXT_DN;
    pmcap_rd = 32'h0000_0000;
    pmcap_rd[`BCPM_ID_MSB:0]                 = `BCPM_CAP_ID;
    pmcap_rd[`BCPM_NXT_MSB:`BCPM_NXT_LSB]    = nxt_ptr;
    pmcap_rd[`BCPM_REV_MSB:`BCPM_REV_LSB]    = `BCPM_PM_REV;
    pmcap_rd[`BCPM_LD_MSB:`BCPM_LD_LSB]      = cap_ld_ff;
  end

  // Unmapped offsets read as zero; every request is answered.
  always_comb begin
    case (cfg_addr_i)
      `BCPM_OFS_BRCTL: nxt_rdata = brctl_rd;
      `BCPM_OFS_PMCAP: nxt_rdata = pmcap_rd;
      default:         nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Configuration answer one cycle after each request.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_ack_o   <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      cfg_ack_o <= cfg_req_i;
      if (cfg_req_i && !cfg_we_i) begin
        cfg_rdata_o <= nxt_rdata;
      end
    end
  end

  // Poisoned packets are reported only when detection is enabled.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      poison_det_o <= 1'b0;
    end else if (ce_i) begin
      poison_det_o <= poison_i && perr_en_ff;
    end
  end

  // Error messages pass to the primary side only when forwarding is enabled.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      err_fwd_o      <= 1'b0;
      err_fwd_type_o <= bcpm_pkg::BCPM_ERR_COR;
    end else if (ce_i) begin
      err_fwd_o <= err_msg_valid_i && err_fwd_en_ff;
      if (err_msg_valid_i && err_fwd_en_ff) begin
        err_fwd_type_o <= err_msg_type_i;
      end
    end
  end

  // Forwarding decisions are registered one cycle after the request.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dec_ack_o     <= 1'b0;
      io_fwd_o      <= 1'b0;
      vga_io_fwd_o  <= 1'b0;
      vga_mem_fwd_o <= 1'b0;
    end else if (ce_i) begin
      dec_ack_o <= dec_req_i;
      if (dec_req_i) begin
        io_fwd_o      <= dec_bus.io_fwd;
        vga_io_fwd_o  <= dec_bus.vga_io_hit;
        vga_mem_fwd_o <= dec_bus.vga_mem_hit;
      end
    end
  end

  // Hot reset of this port's link follows the reset bit.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hot_reset_o <= 1'b0;
    end else if (ce_i) begin
      hot_reset_o <= sbr_ff;
    end
  end

  // Per-port reset outputs, active low.
  genvar gp;
  generate
    for (gp = 0; gp < PORT_COUNT; gp++) begin : g_port_rst
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          port_rst_n_o[gp] <= 1'b1;
        end else if (ce_i) begin
          if (role_ff == bcpm_pkg::BCPM_ROLE_UP) begin
            port_rst_n_o[gp] <= !sbr_ff;
          end else if (gp == OWN_PORT) begin
            port_rst_n_o[gp] <= !sbr_ff;
          end else begin
            port_rst_n_o[gp] <= 1'b1;
          end
        end
      end
    end
  endgenerate

endmodule

// >>> bcpm_regs_chk.sv
// Checker for the bridge control and capability register ports.
`timescale 1ns/10ps
`include "bcpm_defines.svh"
module bcpm_regs_chk #(
  parameter int PORT_COUNT = 2,
  parameter int OWN_PORT   = 0
) (
  // Watched ports
  input wire logic                    ref_clk_i, reset_i, is_upstream_i, cfg_req_i, cfg_we_i,
  input wire logic [`BCPM_ADDR_W-1:0] cfg_addr_i,
  input wire logic [3:0]              cfg_be_i,
  input wire logic [31:0]             cfg_wdata_i, cfg_rdata_o, io_addr_i, mem_addr_i,
  input wire logic                    cap_ld_we_i, poison_i, err_msg_valid_i, poison_det_o,
  input wire logic [`BCPM_LD_W-1:0]   cap_ld_data_i,
  input wire bcpm_pkg::bcpm_err_e     err_msg_type_i, err_fwd_type_o,
  input wire logic                    err_fwd_o, dec_req_i, io_in_win_i, dec_ack_o, io_fwd_o,
  input wire logic                    vga_io_fwd_o, vga_mem_fwd_o, hot_reset_o,
  input wire logic [PORT_COUNT-1:0]   port_rst_n_o
);
  logic [6:0]            ctl_ff;
  logic [`BCPM_LD_W-1:0] ld_ff;
  wire  [9:0]            lo = io_addr_i[9:0];
  wire  wr_ctl = cfg_req_i && cfg_we_i && cfg_addr_i == `BCPM_OFS_BRCTL && cfg_be_i[2];
  wire  vio = ctl_ff[3] && io_addr_i[31:16] == 16'h0 && (!ctl_ff[4] || io_addr_i[15:10] == 6'h0)
    && (lo >= `BCPM_VGA_IO0_LO && lo <= `BCPM_VGA_IO0_HI
    || lo >= `BCPM_VGA_IO1_LO && lo <= `BCPM_VGA_IO1_HI);
  wire  win = io_in_win_i && (!ctl_ff[2] || io_addr_i[31:16] == 16'h0 && io_addr_i[9:8] != 2'h0);
  wire  vmem = ctl_ff[3] && mem_addr_i >= `BCPM_VGA_MEM_LO && mem_addr_i <= `BCPM_VGA_MEM_HI;
  wire  [PORT_COUNT-1:0] rst_on = is_upstream_i ? '0 : ~(PORT_COUNT'(1) << OWN_PORT);
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_ff <= 7'h00;
    end else if (wr_ctl) begin
      ctl_ff <= cfg_wdata_i[22:16] & 7'h5F;
    end
  end
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ld_ff <= `BCPM_LD_RST;
    end else if (cap_ld_we_i) begin
      ld_ff <= cap_ld_data_i;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_rd_ctl; cfg_req_i && !cfg_we_i && cfg_addr_i == `BCPM_OFS_BRCTL; endsequence
  sequence s_rd_cap; cfg_req_i && !cfg_we_i && cfg_addr_i == `BCPM_OFS_PMCAP; endsequence
  property p_poison; 1 |=> poison_det_o == $past(poison_i && ctl_ff[0]); endproperty
  property p_err; err_msg_valid_i |=> err_fwd_o == $past(ctl_ff[1]); endproperty
  property p_ctl; s_rd_ctl |=> cfg_rdata_o == {9'h0, ctl_ff[6], 1'b0, ctl_ff[4:0], 16'h0};
  endproperty
  property p_cap; s_rd_cap |=> cfg_rdata_o == {ld_ff, 5'h03,
    is_upstream_i ? `BCPM_NXT_UP : `BCPM_NXT_DN, `BCPM_CAP_ID}; endproperty
  property p_hot; wr_ctl |-> ##2 hot_reset_o == $past(cfg_wdata_i[22], 2); endproperty
  property p_prst; port_rst_n_o == (hot_reset_o ? rst_on : '1); endproperty
  property p_isa; dec_req_i |=> dec_ack_o && io_fwd_o == $past(win || vio); endproperty
  property p_vio; dec_req_i |=> vga_io_fwd_o == $past(vio); endproperty
  property p_vmem; dec_req_i |=> vga_mem_fwd_o == $past(vmem); endproperty
  a_poison: assert property (p_poison) else $error("poison report wrong");
  a_err: assert property (p_err) else $error("error forward wrong");
  a_ctl: assert property (p_ctl) else $error("control readback wrong");
  a_cap: assert property (p_cap) else $error("capability read wrong");
  a_hot: assert property (p_hot) else $error("hot reset wrong");
  a_prst: assert property (p_prst) else $error("port reset wrong");
  a_isa: assert property (p_isa) else $error("io forward wrong");
  a_vio: assert property (p_vio) else $error("video io wrong");
  a_vmem: assert property (p_vmem) else $error("video memory wrong");
endmodule
bind bcpm_regs bcpm_regs_chk #(.PORT_COUNT(PORT_COUNT), .OWN_PORT(OWN_PORT)) bcpm_regs_chk_inst (
  .ref_clk_i, .reset_i, .is_upstream_i, .cfg_req_i, .cfg_we_i, .cfg_addr_i, .cfg_be_i,
  .cfg_wdata_i, .cfg_rdata_o, .io_addr_i, .mem_addr_i, .cap_ld_we_i, .poison_i, .err_msg_valid_i,
  .poison_det_o, .cap_ld_data_i, .err_msg_type_i, .err_fwd_type_o, .err_fwd_o, .dec_req_i,
  .io_in_win_i, .dec_ack_o, .io_fwd_o, .vga_io_fwd_o, .vga_mem_fwd_o, .hot_reset_o, .port_rst_n_o);

// >>> bcpm_host.sv
// Host model issuing configuration requests on the upstream link.
`timescale 1ns/10ps
module bcpm_host (
  // Clock and answer from the block
  input  wire logic        ref_clk_i,
  input  wire logic        cfg_ack_i,
  input  wire logic [31:0] cfg_rdata_i,
  // Configuration request
  output logic             cfg_req_o = 1'b0,
  output logic             cfg_we_o = 1'b0,
  output logic [7:0]       cfg_addr_o = 8'h00,
  output logic [3:0]       cfg_be_o = 4'h0,
  output logic [31:0]      cfg_wdata_o = 32'h0
);
  task automatic access(input logic we, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] rd, output logic ack);
    @(posedge ref_clk_i);
    cfg_req_o   <= 1'b1;
    cfg_we_o    <= we;
    cfg_addr_o  <= a;
    cfg_be_o    <= be;
    cfg_wdata_o <= d;
    @(posedge ref_clk_i);
    cfg_req_o   <= 1'b0;
    @(posedge ref_clk_i);
    ack = cfg_ack_i;
    rd  = cfg_rdata_i;
    cfg_addr_o  <= ~a;
    cfg_wdata_o <= ~d;
  endtask
endmodule

// >>> bcpm_regs_test.sv
// Self-checking bench for the bridge control and capability registers.
`timescale 1ns/10ps
`include "bcpm_defines.svh"
`define CHECK(act, exp) begin comparisons++; if ((act) !== (exp)) begin bad_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, act, exp); end end
module bcpm_regs_test;
  logic                ref_clk_i = 1'b0, reset_i = 1'b1, is_upstream_i = 1'b0, dec_req_i = 1'b0;
  logic                cap_ld_we_i = 1'b0, poison_i = 1'b0, err_msg_valid_i = 1'b0;
  logic                io_in_win_i = 1'b0, cfg_req_i, cfg_we_i, cfg_ack_o, ackd;
  logic [10:0]         cap_ld_data_i = 11'h000;
  logic [31:0]         io_addr_i = 32'h0, mem_addr_i = 32'h0, cfg_wdata_i, cfg_rdata_o, rdat;
  bcpm_pkg::bcpm_err_e err_msg_type_i = bcpm_pkg::BCPM_ERR_COR, err_fwd_type_o;
  logic                poison_det_o, err_fwd_o, dec_ack_o, io_fwd_o, vga_io_fwd_o;
  logic                vga_mem_fwd_o, hot_reset_o;
  logic [7:0]          cfg_addr_i;
  logic [3:0]          cfg_be_i;
  logic [1:0]          port_rst_n_o;
  int                  bad_count = 0, comparisons = 0, cycles = 0;
  bcpm_regs #(.PORT_COUNT(2), .OWN_PORT(0)) bcpm_regs_inst (.ref_clk_i, .reset_i, .ce_i(1'b1),
    .is_upstream_i, .cfg_req_i, .cfg_we_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_ack_o,
    .cfg_rdata_o, .cap_ld_we_i, .cap_ld_data_i, .poison_i, .err_msg_valid_i, .err_msg_type_i,
    .poison_det_o, .err_fwd_o, .err_fwd_type_o, .dec_req_i, .io_addr_i, .io_in_win_i,
    .mem_addr_i, .dec_ack_o, .io_fwd_o, .vga_io_fwd_o, .vga_mem_fwd_o, .hot_reset_o,
    .port_rst_n_o);
  bcpm_host bcpm_host_inst (.ref_clk_i, .cfg_ack_i(cfg_ack_o), .cfg_rdata_i(cfg_rdata_o),
    .cfg_req_o(cfg_req_i), .cfg_we_o(cfg_we_i), .cfg_addr_o(cfg_addr_i), .cfg_be_o(cfg_be_i),
    .cfg_wdata_o(cfg_wdata_i));
  always #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic do_reset(input logic up);
    @(posedge ref_clk_i);
    reset_i       <= 1'b1;
    is_upstream_i <= up;
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [3:0] be, input logic [7:0] a, input logic [31:0] d);
    bcpm_host_inst.access(1'b1, a, be, d, rdat, ackd);
    `CHECK(ackd, 1'b1)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bcpm_host_inst.access(1'b0, a, 4'hF, 32'h0, rdat, ackd);
    `CHECK({ackd, rdat}, {1'b1, e})
  endtask
  task automatic t_ctl();
    wr(4'hF, `BCPM_OFS_BRCTL, 32'hFFFFFFFF);
    rd(`BCPM_OFS_BRCTL, 32'h005F0000);
    `CHECK({hot_reset_o, port_rst_n_o}, 3'b110)
    wr(4'hB, `BCPM_OFS_BRCTL, 32'h00000000);
    rd(`BCPM_OFS_BRCTL, 32'h005F0000);
    wr(4'hF, `BCPM_OFS_BRCTL, 32'hF0A00000);
    rd(`BCPM_OFS_BRCTL, 32'h00000000);
    `CHECK({hot_reset_o, port_rst_n_o}, 3'b011)
    rd(8'h10, 32'h00000000);
  endtask
  task automatic t_cap();
    rd(`BCPM_OFS_PMCAP, 32'hFFC34C01);
    wr(4'hF, `BCPM_OFS_PMCAP, 32'h00000000);
    rd(`BCPM_OFS_PMCAP, 32'hFFC34C01);
    @(posedge ref_clk_i);
    cap_ld_we_i   <= 1'b1;
    cap_ld_data_i <= 11'h001;
    @(posedge ref_clk_i);
    cap_ld_we_i <= 1'b0;
    rd(`BCPM_OFS_PMCAP, 32'h00234C01);
  endtask
  task automatic t_evt();
    bcpm_pkg::bcpm_err_e kinds[3] = '{bcpm_pkg::BCPM_ERR_COR, bcpm_pkg::BCPM_ERR_NONFATAL,
                                      bcpm_pkg::BCPM_ERR_FATAL};
    for (int en = 0; en < 2; en++) begin
      wr(4'hF, `BCPM_OFS_BRCTL, {14'h0, en[0], en[0], 16'h0});
      foreach (kinds[k]) begin
        @(posedge ref_clk_i);
        poison_i        <= 1'b1;
        err_msg_valid_i <= 1'b1;
        err_msg_type_i  <= kinds[k];
        @(posedge ref_clk_i);
        poison_i        <= 1'b0;
        err_msg_valid_i <= 1'b0;
        #1;
        `CHECK({poison_det_o, err_fwd_o}, {en[0], en[0]})
        if (en == 1) `CHECK(err_fwd_type_o, kinds[k])
      end
    end
  endtask
  task automatic dec(input logic [4:0] c, input logic [31:0] io, input logic w,
                     input logic [31:0] mem, input logic [2:0] e);
    wr(4'hF, `BCPM_OFS_BRCTL, {11'h0, c, 16'h0});
    @(posedge ref_clk_i);
    dec_req_i   <= 1'b1;
    io_addr_i   <= io;
    io_in_win_i <= w;
    mem_addr_i  <= mem;
    @(posedge ref_clk_i);
    dec_req_i <= 1'b0;
    #1;
    `CHECK({dec_ack_o, io_fwd_o, vga_io_fwd_o, vga_mem_fwd_o}, {1'b1, e})
  endtask
  task automatic t_dec();
    dec(5'h00, 32'h10, 1'b1, 32'hA0000, 3'b100);
    dec(5'h04, 32'h10, 1'b1, 32'hA0000, 3'b000);
    dec(5'h04, 32'h310, 1'b1, 32'hA0000, 3'b100);
    dec(5'h04, 32'h10310, 1'b1, 32'hA0000, 3'b000);
    dec(5'h08, 32'h3B0, 1'b0, 32'hA0000, 3'b111);
    dec(5'h08, 32'h7DF, 1'b0, 32'hBFFFF, 3'b111);
    dec(5'h08, 32'h3BC, 1'b0, 32'hC0000, 3'b000);
    dec(5'h18, 32'h7DF, 1'b0, 32'h9FFFF, 3'b000);
    dec(5'h18, 32'h3C0, 1'b0, 32'hA0000, 3'b111);
  endtask
  task automatic t_up();
    do_reset(1'b1);
    rd(`BCPM_OFS_PMCAP, 32'hFFC35C01);
    wr(4'hF, `BCPM_OFS_BRCTL, 32'h00400000);
    @(posedge ref_clk_i);
    #1;
    `CHECK({hot_reset_o, port_rst_n_o}, 3'b100)
    wr(4'hF, `BCPM_OFS_BRCTL, 32'h00000000);
    @(posedge ref_clk_i);
    #1;
    `CHECK({hot_reset_o, port_rst_n_o}, 3'b011)
  endtask
  initial begin
    do_reset(1'b0);
    t_ctl();
    t_cap();
    t_evt();
    t_dec();
    t_up();
    close_out();
  end
endmodule
